/* File: rtl/gsb_defines.svh */
// Register offsets, field positions and codes for the group status bus
`ifndef GSB_DEFINES_SVH
`define GSB_DEFINES_SVH

`define GSB_ADDR_W           8
`define GSB_OFF_CTRL_EN_LINE 8'hb0
`define GSB_OFF_ALARM_SEL    8'hb1
`define GSB_OFF_INT_SUM      8'hb2
`define GSB_OFF_SYNC_SUM     8'hb3
`define GSB_OFF_ALARM_ONE    8'hb4
`define GSB_OFF_ALARM_TWO    8'hb5

`define GSB_RST_BYTE         8'h00
`define GSB_ALL_LINES        8'hff
`define GSB_CTRL1_MASK       8'h0f
`define GSB_CTRL2_MASK       8'h77
`define GSB_EN_BIT           0
`define GSB_LINE_LSB         1
`define GSB_SEL1_LSB         0
`define GSB_SEL2_LSB         4

// Group pin codes: which summary a read is asking for
`define GSB_PIN_INT          2'h0
`define GSB_PIN_SYNC         2'h1
`define GSB_PIN_ONE          2'h2
`define GSB_PIN_TWO          2'h3
`define GSB_DEPTH            2

`endif

/* File: rtl/gsb_pkg.sv */
// Types shared by the group status bus design
`default_nettype none
package gsb_pkg;

    typedef logic [7:0] gsb_byte_t;

    // Alarm inputs presented to the selector
    typedef struct packed {
        logic receive_blue_alarm;
        logic receive_yellow_alarm;
        logic loop_up_detect;
        logic loop_down_detect;
        logic receive_unframed_all_ones;
        logic receive_remote_alarm;
        logic distant_multiframe_alarm;
        logic v5_2_link_detect;
        logic signaling_change;
        logic elastic_store_slip;
    } gsb_alarm_s;

    // Host bus strobe group
    typedef struct packed {
        logic      rd;
        logic      wr;
        gsb_byte_t addr;
        gsb_byte_t wdata;
    } gsb_hostreq_s;

    typedef enum logic [2:0] {
        GSB_IDLE  = 3'b001,
        GSB_OWN   = 3'b010,
        GSB_PEER  = 3'b100
    } gsb_state_e;

endpackage
`default_nettype wire

/* File: rtl/gsb_ctrl_mem.sv */
// Two-entry control register store with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "gsb_defines.svh"

module gsb_ctrl_mem
(
    // Clock and reset
    input  wire logic             i_sys_clk,
    input  wire logic             i_rst,
    // Write port
    input  wire logic             i_we,
    input  wire logic             i_waddr,
    input  wire gsb_pkg::gsb_byte_t i_wdata,
    // Read port
    input  wire logic             i_raddr,
    output gsb_pkg::gsb_byte_t    o_rdata,
    // Raw word view for the control logic
    output gsb_pkg::gsb_byte_t    o_word0,
    output gsb_pkg::gsb_byte_t    o_word1
);

    gsb_pkg::gsb_byte_t mem_q [`GSB_DEPTH];

    // Unused bits forced to zero so they always read back clean
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            mem_q[0] <= `GSB_RST_BYTE;
            mem_q[1] <= `GSB_RST_BYTE;
        end
        else if (i_we)
        begin
            if (i_waddr)
                mem_q[1] <= i_wdata & `GSB_CTRL2_MASK;
            else
                mem_q[0] <= i_wdata & `GSB_CTRL1_MASK;
        end
    end

    // Registered read data
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
            o_rdata <= `GSB_RST_BYTE;
        else
            o_rdata <= mem_q[i_raddr];
    end

    assign o_word0 = mem_q[0];
    assign o_word1 = mem_q[1];

endmodule // gsb_ctrl_mem
`default_nettype wire

/* File: rtl/gsb_status_bus.sv */
// Group status sharing logic: registers, group pins and data-line drive
`timescale 1ns/1ps
`default_nettype none
`include "gsb_defines.svh"

////////////////////////////////////////////////////////////////////////////////
module gsb_status_bus
(
    // Clock and reset
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_rst,
    // Host bus request, one cycle strobes
    input  wire gsb_pkg::gsb_hostreq_s i_host,
    // Host data bus answer
    output gsb_pkg::gsb_byte_t        o_rdata,
    output gsb_pkg::gsb_byte_t        o_rdata_oe,
    // Device status inputs
    input  wire logic                 i_e1_mode,
    input  wire logic                 i_interrupt_pending,
    input  wire logic                 i_sync_loss,
    input  wire gsb_pkg::gsb_alarm_s  i_alarms,
    // Group select line a, open drain
    input  wire logic                 i_group_select_line_a,
    output logic                      o_group_select_line_a,
    output logic                      o_group_select_line_a_oe,
    // Group select line b, open drain
    input  wire logic                 i_group_select_line_b,
    output logic                      o_group_select_line_b,
    output logic                      o_group_select_line_b_oe,
    // Group read line, open drain, active low
    input  wire logic                 i_group_read_line,
    output logic                      o_group_read_line,
    output logic                      o_group_read_line_oe,
    // Control state view
    output logic                      o_group_enable
);

    ////////////////////////////////////////////////////////////////////////////
    // Alarm selection, shared by both select fields

    // Map a 3-bit select code to one alarm; codes 6 and 7 show nothing
    function automatic logic alarm_pick(input logic [2:0] code,
                                        input logic e1,
                                        input gsb_pkg::gsb_alarm_s a);
        logic r;
        r = 1'b0;
        case (code)
            3'h0: r = e1 ? a.receive_unframed_all_ones : a.receive_blue_alarm;
            3'h1: r = e1 ? a.receive_remote_alarm : a.receive_yellow_alarm;
            3'h2: r = e1 ? a.distant_multiframe_alarm : a.loop_up_detect;
            3'h3: r = e1 ? a.v5_2_link_detect : a.loop_down_detect;
            3'h4: r = a.signaling_change;
            3'h5: r = a.elastic_store_slip;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // True when an address is one of the four summary offsets
    function automatic logic is_summary(input gsb_pkg::gsb_byte_t adr);
        return (adr >= `GSB_OFF_INT_SUM) && (adr <= `GSB_OFF_ALARM_TWO);
    endfunction

    // Offset of a summary from the first one gives its pin code
    function automatic logic [1:0] pin_code(input gsb_pkg::gsb_byte_t adr);
        gsb_pkg::gsb_byte_t d;
        d = adr - `GSB_OFF_INT_SUM;
        return d[1:0];
    endfunction

    // The two control offsets, used by the write and the read path
    function automatic logic is_ctrl(input gsb_pkg::gsb_byte_t adr);
        return (adr == `GSB_OFF_CTRL_EN_LINE) ||
               (adr == `GSB_OFF_ALARM_SEL);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Control registers

    gsb_pkg::gsb_byte_t ctrl1;
    gsb_pkg::gsb_byte_t ctrl2;
    gsb_pkg::gsb_byte_t ctrl_rdata;
    logic               ctrl_we;
    logic               ctrl_rd_q;
    logic               en;
    logic [2:0]         line_sel;
    logic [2:0]         sel_one;
    logic [2:0]         sel_two;

    // Masking in the store covers hosts that ignore the zero-write duty
    assign ctrl_we = i_host.wr && is_ctrl(i_host.addr);

    // Store read data is registered, so the answer goes out one edge later
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
            ctrl_rd_q <= 1'b0;
        else
            ctrl_rd_q <= i_host.rd && is_ctrl(i_host.addr);
    end

    // Store masks unused bits on write and registers its read data
    gsb_ctrl_mem u_ctrl_mem
    (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_we      (ctrl_we),
        .i_waddr   (i_host.addr == `GSB_OFF_ALARM_SEL),
        .i_wdata   (i_host.wdata),
        .i_raddr   (i_host.addr == `GSB_OFF_ALARM_SEL),
        .o_rdata   (ctrl_rdata),
        .o_word0   (ctrl1),
        .o_word1   (ctrl2)
    );

    // Field extraction
    assign en       = ctrl1[`GSB_EN_BIT];
    assign line_sel = ctrl1[`GSB_LINE_LSB +: 3];
    assign sel_one  = ctrl2[`GSB_SEL1_LSB +: 3];
    assign sel_two  = ctrl2[`GSB_SEL2_LSB +: 3];

    ////////////////////////////////////////////////////////////////////////////
    // Own status bit chosen by a pin code

    // Shared by own and peer reads so both use one status map
    function automatic logic status_bit(input logic [1:0] code);
        logic b;
        b = 1'b0;
        case (code)
            `GSB_PIN_INT:  b = i_interrupt_pending;
            `GSB_PIN_SYNC: b = i_sync_loss;
            `GSB_PIN_ONE:
                b = alarm_pick(sel_one, i_e1_mode, i_alarms);
            `GSB_PIN_TWO:
                b = alarm_pick(sel_two, i_e1_mode, i_alarms);
            default:       b = 1'b0;
        endcase
        return b;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Group read sequencing

    gsb_pkg::gsb_state_e state_q;
    gsb_pkg::gsb_state_e state_d;
    logic                own_sum;
    logic                peer_read;
    logic [1:0]          peer_code;
    logic [1:0]          own_code;

    // A read here starts a group read; a peer announces one on the pins
    assign own_sum   = i_host.rd && is_summary(i_host.addr) && en;
    // Our own pull on the read line is no peer read: no echo answer
    assign peer_read = !i_group_read_line && !o_group_read_line_oe &&
                       en;
    assign peer_code = {i_group_select_line_b, i_group_select_line_a};
    assign own_code  = pin_code(i_host.addr);

    // Own read holds the pins one cycle; peer read answers while low
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            gsb_pkg::GSB_IDLE:
                if (own_sum)
                    state_d = gsb_pkg::GSB_OWN;
                else if (peer_read)
                    state_d = gsb_pkg::GSB_PEER;
            gsb_pkg::GSB_OWN:
                state_d = gsb_pkg::GSB_IDLE;
            gsb_pkg::GSB_PEER:
                if (!peer_read)
                    state_d = gsb_pkg::GSB_IDLE;
            default:
                state_d = gsb_pkg::GSB_IDLE;
        endcase
    end

    // Sequencer state; a stray code falls back to idle
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
            state_q <= gsb_pkg::GSB_IDLE;
        else
            state_q <= state_d;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Group pins, driven low only, released high by the pullups

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_group_read_line_oe     <= 1'b0;
            o_group_select_line_a_oe <= 1'b0;
            o_group_select_line_b_oe <= 1'b0;
        end
        else if (state_d == gsb_pkg::GSB_OWN)
        begin
            // Open drain: enable only where the code bit is zero
            o_group_read_line_oe     <= 1'b1;
            o_group_select_line_a_oe <= !own_code[0];
            o_group_select_line_b_oe <= !own_code[1];
        end
        else
        begin
            // Disabled members never leave idle, so pins stay free
            o_group_read_line_oe     <= 1'b0;
            o_group_select_line_a_oe <= 1'b0;
            o_group_select_line_b_oe <= 1'b0;
        end
    end

    // Open-drain data levels are always low
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_group_read_line     <= 1'b0;
            o_group_select_line_a <= 1'b0;
            o_group_select_line_b <= 1'b0;
        end
        else
        begin
            o_group_read_line     <= 1'b0;
            o_group_select_line_a <= 1'b0;
            o_group_select_line_b <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Host data answer

    // Summary and peer answers drive only the selected line, so distinct lines never clash
    function automatic gsb_pkg::gsb_byte_t line_onehot(input logic [2:0] s);
        return gsb_pkg::gsb_byte_t'(8'h01 << s);
    endfunction

    // Own strobe first, then a peer read, then a pending control answer
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_rdata    <= `GSB_RST_BYTE;
            o_rdata_oe <= `GSB_RST_BYTE;
        end
        else if (own_sum)
        begin
            o_rdata    <= status_bit(pin_code(i_host.addr)) ?
                          line_onehot(line_sel) : `GSB_RST_BYTE;
            o_rdata_oe <= line_onehot(line_sel);
        end
        else if (i_host.rd && is_summary(i_host.addr))
        begin
            // Not in the group: the summary reads as all zero
            o_rdata    <= `GSB_RST_BYTE;
            o_rdata_oe <= `GSB_RST_BYTE;
        end
        else if (peer_read)
        begin
            o_rdata    <= status_bit(peer_code) ?
                          line_onehot(line_sel) : `GSB_RST_BYTE;
            o_rdata_oe <= line_onehot(line_sel);
        end
        else if (ctrl_rd_q)
        begin
            // Registered store data is ready now, drive it with the enables
            o_rdata    <= ctrl_rdata;
            o_rdata_oe <= `GSB_ALL_LINES;
        end
        else
        begin
            o_rdata    <= `GSB_RST_BYTE;
            o_rdata_oe <= `GSB_RST_BYTE;
        end
    end

    // Group enable exported; loaded with the store, so it never lags
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
            o_group_enable <= 1'b0;
        else if (ctrl_we && (i_host.addr == `GSB_OFF_CTRL_EN_LINE))
            o_group_enable <= i_host.wdata[`GSB_EN_BIT];
    end

endmodule // gsb_status_bus
`default_nettype wire

/* File: verification/gsb_peer_model.sv */
// Peer member model that pulls the shared group pins in each cycle after one with i_go high
`timescale 1ns/1ps
`default_nettype none
module gsb_peer_model
(
    // Clock and reset
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst,
    // Read request from the bench
    input  wire logic       i_go,
    input  wire logic [1:0] i_code,
    // Open-drain pulls, high pulls the line low
    output logic            o_read_oe,
    output logic            o_sel_a_oe,
    output logic            o_sel_b_oe
);
    // Low code bits pull; it owns another data line, so drives none here
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            {o_read_oe, o_sel_a_oe, o_sel_b_oe} <= 3'h0;
        end
        else
        begin
            o_read_oe  <= i_go;
            o_sel_a_oe <= i_go & ~i_code[0];
            o_sel_b_oe <= i_go & ~i_code[1];
        end
    end
endmodule // gsb_peer_model
`default_nettype wire

/* File: verification/gsb_status_bus_monitor.sv */
// Port checks for the group status bus
`timescale 1ns/1ps
`default_nettype none
module gsb_status_bus_monitor
(
    // Clock and reset
    input wire logic                  i_sys_clk,
    input wire logic                  i_rst,
    // Host side
    input wire gsb_pkg::gsb_hostreq_s i_host,
    input wire gsb_pkg::gsb_byte_t    o_rdata,
    input wire gsb_pkg::gsb_byte_t    o_rdata_oe,
    // Status and group pins
    input wire logic                  i_interrupt_pending,
    input wire logic                  i_group_read_line,
    input wire logic                  o_group_select_line_a_oe,
    input wire logic                  o_group_select_line_b_oe,
    input wire logic                  o_group_read_line_oe,
    input wire logic                  o_group_enable
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    // Enabled host read of a given summary
    wire logic rd_en = i_host.rd & o_group_enable;
    ////////////////////////////////////////////////////////////////////////
    en_store_a: assert property (i_host.wr && i_host.addr == 8'hb0
        && i_host.wdata[0] |-> ##[1:2] o_group_enable) else $error("no enable");
    int_bit_a: assert property (rd_en && i_host.addr == 8'hb2 |=>
        (|(o_rdata & o_rdata_oe)) == $past(i_interrupt_pending))
        else $error("bad interrupt bit");
    read_pins_a: assert property (rd_en && i_host.addr == 8'hb3 |=>
        o_group_read_line_oe && o_group_select_line_b_oe
        && !o_group_select_line_a_oe) else $error("bad pin code");
    line_onehot_a: assert property (o_rdata_oe != 8'hff |->
        $onehot0(o_rdata_oe)) else $error("several lines driven");
    refuse_a: assert property (i_host.rd && i_host.addr == 8'hc0 |=>
        o_rdata_oe == 8'h00) else $error("unmapped read drove");
    idle_off_a: assert property (!o_group_enable
        && !$past(o_group_enable) |-> !(o_group_read_line_oe
        || o_group_select_line_a_oe || o_group_select_line_b_oe))
        else $error("disabled member pulled pins");
    peer_take_a: assert property (o_group_enable && !i_group_read_line
        && !o_group_read_line_oe && !i_host.rd |=> $onehot(o_rdata_oe))
        else $error("no answer to peer");
endmodule // gsb_status_bus_monitor
bind gsb_status_bus gsb_status_bus_monitor i_gsb_status_bus_monitor
(
    .i_sys_clk, .i_rst, .i_host, .o_rdata, .o_rdata_oe, .i_interrupt_pending,
    .i_group_read_line, .o_group_select_line_a_oe, .o_group_select_line_b_oe,
    .o_group_read_line_oe, .o_group_enable
);
`default_nettype wire

/* File: verification/test_gsb_status_bus.sv */
// Self-checking bench for the group status bus
`timescale 1ns/1ps
`default_nettype none
module test_gsb_status_bus;
    logic                  i_sys_clk;
    logic                  i_rst;
    logic                  e1, pend, sloss, go, rd_oe, sa_oe, sb_oe, en;
    logic                  prd, psa, psb, rd_o, sa_o, sb_o;
    logic [1:0]            code;
    logic [9:0]            alv;
    gsb_pkg::gsb_hostreq_s host;
    gsb_pkg::gsb_byte_t    rdata, oe;
    int                    err_count, num_checks, cyc, idx;
    // Pull-ups: a line reads high unless a member pulls it
    wire logic             rd_w = ~(rd_oe | prd);
    wire logic             sa_w = ~(sa_oe | psa);
    wire logic             sb_w = ~(sb_oe | psb);
    // Own pin levels and pulls, packed for one compare
    wire logic [7:0]       pins = {2'h0, rd_o, sb_o, sa_o,
                                   rd_oe, sb_oe, sa_oe};
    gsb_status_bus i_gsb_status_bus
    (
        .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_host(host),
        .o_rdata(rdata), .o_rdata_oe(oe), .i_e1_mode(e1),
        .i_interrupt_pending(pend), .i_sync_loss(sloss), .i_alarms(alv),
        .i_group_select_line_a(sa_w), .o_group_select_line_a(sa_o),
        .o_group_select_line_a_oe(sa_oe), .i_group_select_line_b(sb_w),
        .o_group_select_line_b(sb_o), .o_group_select_line_b_oe(sb_oe),
        .i_group_read_line(rd_w), .o_group_read_line(rd_o),
        .o_group_read_line_oe(rd_oe), .o_group_enable(en)
    );
    gsb_peer_model i_gsb_peer_model
    (
        .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_go(go), .i_code(code),
        .o_read_oe(prd), .o_sel_a_oe(psa), .o_sel_b_oe(psb)
    );
    ////////////////////////////////////////////////////////////////////////
    // Clock, 40 ns period
    initial
    begin
        i_sys_clk = 1'b0;
        forever #20 i_sys_clk = ~i_sys_clk;
    end
    // Verdict, reached from the end of the run or the hang guard
    task end_of_test;
        $display("checks=%0d errors=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Guard against a hung run
    always @(posedge i_sys_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            err_count++;
            end_of_test();
        end
    end
    task chk(input gsb_pkg::gsb_byte_t seen, input gsb_pkg::gsb_byte_t exp);
        num_checks++;
        if (seen !== exp)
        begin
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
            err_count++;
        end
    endtask
    // One strobe; address stays held for the late control data
    task acc(input logic r, input logic w, input gsb_pkg::gsb_byte_t a,
             input gsb_pkg::gsb_byte_t d);
        @(posedge i_sys_clk);
        #1 host = {r, w, a, d};
        @(posedge i_sys_clk);
        #1 host.rd = 1'b0;
        host.wr = 1'b0;
    endtask
    task ctl(input gsb_pkg::gsb_byte_t a, input gsb_pkg::gsb_byte_t exp);
        acc(1'b1, 1'b0, a, 8'h00);
        @(posedge i_sys_clk);
        #1 chk(rdata, exp);
        chk(oe, 8'hff);
    endtask
    task sum(input gsb_pkg::gsb_byte_t a, input logic v, input int ln);
        gsb_pkg::gsb_byte_t c;
        c = a - 8'hb2;
        acc(1'b1, 1'b0, a, 8'h00);
        chk(oe, 8'h01 << ln);
        chk(rdata, v ? 8'h01 << ln : 8'h00);
        chk(pins, {6'h01, ~c[1:0]});
        // Answer and pin pulls stand one cycle only
        @(posedge i_sys_clk);
        #1 chk(oe | pins, 8'h00);
    endtask
    // Peer pulls read line one cycle; answer lands two edges later
    task peer(input logic [1:0] c);
        @(posedge i_sys_clk);
        #1 go = 1'b1;
        code = c;
        @(posedge i_sys_clk);
        #1 go = 1'b0;
        @(posedge i_sys_clk);
        #1;
    endtask
    initial
    begin
        {i_rst, e1, pend, sloss, go, code, alv} = {1'b1, 16'h0000};
        host = '0;
        repeat (10) @(posedge i_sys_clk);
        #1 i_rst = 1'b0;
        ctl(8'hb0, 8'h00);
        ctl(8'hb1, 8'h00);
        acc(1'b1, 1'b0, 8'hb2, 8'h00);
        chk(oe, 8'h00);
        acc(1'b0, 1'b1, 8'hb0, 8'h0f);
        ctl(8'hb0, 8'h0f);
        chk({7'h00, en}, 8'h01);
        for (int ln = 0; ln < 8; ln++)
        begin
            acc(1'b0, 1'b1, 8'hb0, gsb_pkg::gsb_byte_t'(ln * 2 + 1));
            pend = ln[0];
            sum(8'hb2, pend, ln);
        end
        acc(1'b0, 1'b1, 8'hb0, 8'h0b);
        sloss = 1'b1;
        sum(8'hb3, 1'b1, 5);
        sloss = 1'b0;
        sum(8'hb3, 1'b0, 5);
        // Every select code in both modes, target low then high
        for (int m = 0; m < 2; m++)
            for (int k = 0; k < 8; k++)
                for (int v = 0; v < 2; v++)
                begin
                    e1 = m[0];
                    acc(1'b0, 1'b1, 8'hb1, gsb_pkg::gsb_byte_t'(k * 17));
                    alv = v ? 10'h000 : 10'h3ff;
                    idx = (m == 1 || k > 3) ? 5 - k : 9 - k;
                    if (k < 6)
                        alv[idx] = v[0];
                    sum(8'hb4, v == 1 && k < 6, 5);
                    sum(8'hb5, v == 1 && k < 6, 5);
                end
        // Peer reads: interrupt and first alarm high, others low
        {e1, pend, sloss, alv} = {3'h2, 10'h3ff};
        acc(1'b0, 1'b1, 8'hb1, 8'h60);
        for (int c = 0; c < 4; c++)
        begin
            peer(c[1:0]);
            chk(oe, 8'h20);
            chk(rdata, c[0] ? 8'h00 : 8'h20);
        end
        acc(1'b1, 1'b0, 8'hc0, 8'h00);
        chk(oe, 8'h00);
        acc(1'b0, 1'b1, 8'hb0, 8'h00);
        chk({7'h00, en}, 8'h00);
        peer(2'h0);
        chk(oe, 8'h00);
        end_of_test();
    end
endmodule // test_gsb_status_bus
`default_nettype wire
